// >>> common/pwr_mgmt_pkg.sv
/*
  Shared constants and types for the power mode and clock manager.
  Assumes a 100 MHz system clock and APB access with word-aligned byte addresses.
*/
package pwr_mgmt_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_CLOCK_SELECT = 8'ha3;
  localparam logic [7:0] IDX_CPU_STANDBY = 8'ha4;
  localparam logic [7:0] IDX_WAKE_CONFIG = 8'ha5;
  localparam logic [7:0] IDX_RESET_CAUSE = 8'hb1;
  localparam logic [7:0] IDX_USB_SLEEP = 8'hb2;
  localparam logic [7:0] IDX_WAKE_FLAGS = 8'hb3;
  localparam logic [7:0] IDX_POWER_STATUS = 8'hb4;
  localparam logic [7:0] IDX_RADIO_CONTROL = 8'hb5;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hb8;
  // Reset values
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_CLOCK_SELECT = 8'h80;
  localparam logic [7:0] RST_WAKE_CONFIG = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [1:0] RST_RADIO_MODE = 2'h0;
  // Clock select fields
  localparam int CLK_PLL_EN_BIT = 7;
  localparam int CLK_FAST_LSB = 4;
  localparam int CLK_SLOW_LSB = 0;
  // Standby control fields
  localparam int STBY_REQ_MSB = 2;
  localparam int STBY_SLOW_BIT = 3;
  // Power control fields
  localparam int POWER_CONTROL_IDLE_BIT = 0;
  localparam int POWER_CONTROL_STOP_BIT = 1;
  localparam int POWER_CONTROL_PMW_BIT = 4;
  localparam int POWER_CONTROL_BAUD_BIT = 7;
  localparam logic [7:0] POWER_CONTROL_STORED_MASK = 8'hfc;
  // Wake config codes
  localparam logic [1:0] WAKE_IF_ENABLED = 2'h0;
  localparam logic [1:0] WAKE_ALWAYS = 2'h2;
  // Enable bit per source in the second interrupt-enable register
  localparam int IEN_RF_BIT = 1;
  localparam int IEN_WU_BIT = 5;
  localparam int IEN_USB_INTERRUPT_BIT = 4;
  localparam int IEN_USB_RESUME_EVENT_BIT = 3;
  // Timing: slow clock derived from system clock
  localparam int SYS_CLK_HZ = 100_000_000;
  localparam int SLOW_CLK_HZ = 32_000;
  localparam int SLOW_HALF_CYCLES = SYS_CLK_HZ / (2 * SLOW_CLK_HZ);
  // CPU clock frequencies in kHz
  localparam logic [15:0] KHZ_16M = 16'h3e80;
  localparam logic [15:0] KHZ_12M = 16'h2ee0;
  localparam logic [15:0] KHZ_8M = 16'h1f40;
  localparam logic [15:0] KHZ_4M = 16'h0fa0;
  localparam logic [15:0] KHZ_1M6 = 16'h0640;
  localparam logic [15:0] KHZ_320K = 16'h0140;
  localparam logic [15:0] KHZ_64K = 16'h0040;

  // Wakeup sources, one bit each
  typedef struct packed {
    logic rfIrq;
    logic wakeEvent;
    logic usb_interrupt;
    logic usbResume;
  } wake_src_t;

  // CPU run state
  typedef enum logic {CPU_ACTIVE, CPU_STANDBY} cpu_state_t;
endpackage : pwr_mgmt_pkg

// >>> logic/power_mode_clock_manager.sv
/*
  Power mode and clock manager: CPU standby and wakeup, USB suspend, PLL
  control, CPU clock selection, slow clock, reset cause and power control.
  Assumes an APB master on sys_clk, wake sources synchronous to sys_clk,
  and program pin and watchdog cause arriving asynchronously.
*/
`timescale 1ns/100ps

module power_mode_clock_manager (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and reset generator
  input wire logic programModePin,
  input wire logic watchdogResetCause,
  // Wake sources, same clock domain
  input wire pwr_mgmt_pkg::wake_src_t wakeSrc,
  // Power state outputs
  output logic cpuClockRun,
  output logic [15:0] cpuClockKhz,
  output logic pllEnable,
  output logic usbActive,
  output logic [1:0] radioMode,
  output logic flashProgMode,
  output logic slowClock,
  output pwr_mgmt_pkg::wake_src_t wakeFlagPulse,
  // Legacy power control outputs
  output logic idleRequest,
  output logic stopRequest,
  output logic progMemWrite,
  output logic baudDouble
);

  // Synchronisers for pin inputs
  logic progMeta;
  logic progSync;
  logic wdogMeta;
  logic wdogSync;
  // Reset cause capture sequencing
  logic [1:0] captureCount;
  logic resetCause;
  // Software visible registers
  logic [7:0] powerControl;
  logic [7:0] clockSelect;
  logic [7:0] wakeConfig;
  logic [7:0] irqEnable;
  logic [1:0] radioControl;
  pwr_mgmt_pkg::wake_src_t wakeFlags;
  // State
  pwr_mgmt_pkg::cpu_state_t cpuState;
  logic usbSuspended;
  logic [10:0] slowCount;

  // APB decode
  wire [7:0] wordIdx = paddr[9:2];
  wire aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  wire setupPhase = psel && !penable;
  wire accessWrite = psel && penable && pwrite;
  wire hitPcon = aligned && (wordIdx == pwr_mgmt_pkg::IDX_POWER_CONTROL);
  wire hitClock = aligned && (wordIdx == pwr_mgmt_pkg::IDX_CLOCK_SELECT);
  wire hitStandby = aligned && (wordIdx == pwr_mgmt_pkg::IDX_CPU_STANDBY);
  wire hitWake = aligned && (wordIdx == pwr_mgmt_pkg::IDX_WAKE_CONFIG);
  wire hitCause = aligned && (wordIdx == pwr_mgmt_pkg::IDX_RESET_CAUSE);
  wire hitUsb = aligned && (wordIdx == pwr_mgmt_pkg::IDX_USB_SLEEP);
  wire hitFlags = aligned && (wordIdx == pwr_mgmt_pkg::IDX_WAKE_FLAGS);
  wire hitStatus = aligned && (wordIdx == pwr_mgmt_pkg::IDX_POWER_STATUS);
  wire hitRadio = aligned && (wordIdx == pwr_mgmt_pkg::IDX_RADIO_CONTROL);
  wire hitIrqEn = aligned && (wordIdx == pwr_mgmt_pkg::IDX_IRQ_ENABLE);
  wire mapped = hitPcon || hitClock || hitStandby || hitWake || hitCause
    || hitUsb || hitFlags || hitStatus || hitRadio || hitIrqEn;
  // Write strobes, taken in the access phase only
  wire wrPcon = accessWrite && hitPcon;
  wire wrClock = accessWrite && hitClock;
  wire wrStandby = accessWrite && hitStandby;
  wire wrWake = accessWrite && hitWake;
  wire wrUsb = accessWrite && hitUsb;
  wire wrFlags = accessWrite && hitFlags;
  wire wrRadio = accessWrite && hitRadio;
  wire wrIrqEn = accessWrite && hitIrqEn;

  // Derived state
  wire cpuStandby = (cpuState == pwr_mgmt_pkg::CPU_STANDBY);
  wire standbyReq = wrStandby && (pwdata[pwr_mgmt_pkg::STBY_REQ_MSB:0] != 3'h0);
  wire progMode = progSync;

  // Wake decode: code 00 needs enable, 10 wakes always, 11 and 01 never
  function automatic logic wakeAllowed(input logic [1:0] code, input logic enable);
    wakeAllowed = (code == pwr_mgmt_pkg::WAKE_ALWAYS)
      || ((code == pwr_mgmt_pkg::WAKE_IF_ENABLED) && enable);
  endfunction : wakeAllowed

  // Per-source config fields and enable bits
  wire [3:0][1:0] srcCode = wakeConfig;
  wire [3:0] srcEnable = {irqEnable[pwr_mgmt_pkg::IEN_RF_BIT],
    irqEnable[pwr_mgmt_pkg::IEN_WU_BIT], irqEnable[pwr_mgmt_pkg::IEN_USB_INTERRUPT_BIT],
    irqEnable[pwr_mgmt_pkg::IEN_USB_RESUME_EVENT_BIT]};
  wire [3:0] srcLevel = wakeSrc;
  logic [3:0] wakeHit;

  // One wake qualifier per source, only while the CPU sleeps
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_wake
      assign wakeHit[gi] = cpuStandby && !progMode && srcLevel[gi]
        && wakeAllowed(srcCode[gi], srcEnable[gi]);
    end
  endgenerate
  wire anyWake = |wakeHit;

  // PLL follows USB outside program mode; software bit only with USB suspended and CPU running
  wire pllOnNow = !progMode && (!usbSuspended
    || (!cpuStandby && clockSelect[pwr_mgmt_pkg::CLK_PLL_EN_BIT]));

  // CPU clock frequency from the field that matches the PLL state
  wire [2:0] fastSel = clockSelect[pwr_mgmt_pkg::CLK_FAST_LSB +: 3];
  wire [1:0] slowSel = clockSelect[pwr_mgmt_pkg::CLK_SLOW_LSB +: 2];
  logic [15:0] selKhz;
  always_comb
  begin
    // Reserved fast codes 4 to 7 fall back to 1.6 MHz
    selKhz = pwr_mgmt_pkg::KHZ_1M6;
    if (pllOnNow)
      unique case (fastSel)
        3'h0: selKhz = pwr_mgmt_pkg::KHZ_16M;
        3'h1: selKhz = pwr_mgmt_pkg::KHZ_12M;
        3'h2: selKhz = pwr_mgmt_pkg::KHZ_8M;
        3'h3: selKhz = pwr_mgmt_pkg::KHZ_4M;
        default: selKhz = pwr_mgmt_pkg::KHZ_1M6;
      endcase
    else
      unique case (slowSel)
        2'h0: selKhz = pwr_mgmt_pkg::KHZ_4M;
        2'h1: selKhz = pwr_mgmt_pkg::KHZ_1M6;
        2'h2: selKhz = pwr_mgmt_pkg::KHZ_320K;
        2'h3: selKhz = pwr_mgmt_pkg::KHZ_64K;
      endcase
  end

  // Read mux; stop and idle always read zero
  logic [7:0] readByte;
  always_comb
  begin
    readByte = 8'h00;
    if (hitPcon) readByte = powerControl & pwr_mgmt_pkg::POWER_CONTROL_STORED_MASK;
    else if (hitClock) readByte = clockSelect;
    else if (hitStandby) readByte = {4'h0, slowClock, 3'h0};
    else if (hitWake) readByte = wakeConfig;
    else if (hitCause) readByte = {7'h00, resetCause};
    else if (hitUsb) readByte = {7'h00, usbSuspended};
    else if (hitFlags) readByte = {4'h0, wakeFlags};
    else if (hitStatus)
      readByte = {2'h0, radioControl, progMode, pllEnable, usbActive, !cpuStandby};
    else if (hitRadio) readByte = {6'h00, radioControl};
    else if (hitIrqEn) readByte = irqEnable;
  end

  // No wait states
  assign pready = 1'b1;

  // Read data and error latched in the setup phase, shown in access
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setupPhase)
    begin
      prdata <= {24'h000000, readByte};
      pslverr <= !mapped;
    end
  end

  // Two-flop synchronisers for program pin and watchdog cause
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      progMeta <= 1'b0;
      progSync <= 1'b0;
      wdogMeta <= 1'b0;
      wdogSync <= 1'b0;
    end
    else
    begin
      progMeta <= programModePin;
      progSync <= progMeta;
      wdogMeta <= watchdogResetCause;
      wdogSync <= wdogMeta;
    end
  end

  // Reset cause caught once the synchroniser has settled after release
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      captureCount <= 2'h0;
      resetCause <= 1'b0;
    end
    else if (captureCount != 2'h3)
    begin
      captureCount <= captureCount + 2'h1;
      if (captureCount == 2'h2)
        resetCause <= wdogSync;
    end
  end

  // Software registers; every reset source gives the same state
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      powerControl <= pwr_mgmt_pkg::RST_POWER_CONTROL;
      clockSelect <= pwr_mgmt_pkg::RST_CLOCK_SELECT;
      wakeConfig <= pwr_mgmt_pkg::RST_WAKE_CONFIG;
      irqEnable <= pwr_mgmt_pkg::RST_IRQ_ENABLE;
      radioControl <= pwr_mgmt_pkg::RST_RADIO_MODE;
    end
    else
    begin
      // Flags and mode bits; stop and idle never stored
      if (wrPcon) powerControl <= pwdata[7:0] & pwr_mgmt_pkg::POWER_CONTROL_STORED_MASK;
      // Unused bits 3:2 stay zero
      if (wrClock) clockSelect <= pwdata[7:0] & 8'hf3;
      if (wrWake) wakeConfig <= pwdata[7:0];
      if (wrIrqEn) irqEnable <= pwdata[7:0];
      // Radio moves only under software control
      if (wrRadio) radioControl <= pwdata[1:0];
    end
  end

  // Legacy mode pulses and flag outputs
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idleRequest <= 1'b0;
      stopRequest <= 1'b0;
    end
    else
    begin
      idleRequest <= wrPcon && pwdata[pwr_mgmt_pkg::POWER_CONTROL_IDLE_BIT];
      stopRequest <= wrPcon && pwdata[pwr_mgmt_pkg::POWER_CONTROL_STOP_BIT];
    end
  end
  assign progMemWrite = powerControl[pwr_mgmt_pkg::POWER_CONTROL_PMW_BIT];
  assign baudDouble = powerControl[pwr_mgmt_pkg::POWER_CONTROL_BAUD_BIT];
  assign radioMode = radioControl;
  assign flashProgMode = progMode;

  // CPU state machine: a wake in standby wins over a standby write in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cpuState <= pwr_mgmt_pkg::CPU_ACTIVE;
    else
      unique case (cpuState)
        pwr_mgmt_pkg::CPU_ACTIVE:
          if (standbyReq && !progMode)
            cpuState <= pwr_mgmt_pkg::CPU_STANDBY;
        pwr_mgmt_pkg::CPU_STANDBY:
          if (anyWake)
            cpuState <= pwr_mgmt_pkg::CPU_ACTIVE;
      endcase
  end

  // USB suspend: a host resume wins over a suspend write
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      usbSuspended <= 1'b0;
    else if (wakeSrc.usbResume)
      usbSuspended <= 1'b0;
    else if (wrUsb)
      usbSuspended <= (pwdata[7:0] == 8'h01);
  end

  // Wake flags: set only on a wakeup that the code and enable allow, write one to clear
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wakeFlags <= '0;
      wakeFlagPulse <= '0;
    end
    else
    begin
      wakeFlags <= (wakeFlags & ~(wrFlags ? pwdata[3:0] : 4'h0)) | wakeHit;
      wakeFlagPulse <= wakeHit;
    end
  end

  // Slow clock divided from the system clock, never stopped
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      slowCount <= 11'h000;
      slowClock <= 1'b0;
    end
    else if (slowCount == 11'(pwr_mgmt_pkg::SLOW_HALF_CYCLES - 1))
    begin
      slowCount <= 11'h000;
      slowClock <= !slowClock;
    end
    else
      slowCount <= slowCount + 11'h001;
  end

  // Clock outputs; PLL enable gates the 3x multiplier outside
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpuClockRun <= 1'b1;
      cpuClockKhz <= pwr_mgmt_pkg::KHZ_16M;
      pllEnable <= 1'b1;
      usbActive <= 1'b1;
    end
    else
    begin
      cpuClockRun <= !cpuStandby || anyWake;
      cpuClockKhz <= selKhz;
      pllEnable <= pllOnNow;
      usbActive <= !usbSuspended;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // A wake right after entry keeps the clock running, which is intended
  a_standby_entry: assert property (
    standbyReq && !progMode && !cpuStandby |=> cpuStandby ##1 (!cpuClockRun || $past(anyWake)))
    else $error("standby write did not stop the CPU clock");
  a_wake_restart: assert property (
    cpuStandby && anyWake |=> !cpuStandby && cpuClockRun && cpuClockKhz == $past(selKhz))
    else $error("wakeup did not restart CPU clock");
  a_wake_ignored: assert property (
    cpuStandby && wakeConfig == 8'hff && !standbyReq |=> cpuStandby)
    else $error("ignored source woke the CPU");
  a_pll_usb_on: assert property (!usbSuspended && !progMode |=> pllEnable)
    else $error("PLL off while USB active");
  a_pll_sleep_off: assert property (usbSuspended && cpuStandby |=> !pllEnable)
    else $error("PLL on with USB suspended and CPU standby");
  a_fast_select: assert property (
    pllOnNow && fastSel == 3'h1 |=> cpuClockKhz == pwr_mgmt_pkg::KHZ_12M)
    else $error("wrong fast CPU clock");
  a_slow_select: assert property (
    !pllOnNow && slowSel == 2'h3 |=> cpuClockKhz == pwr_mgmt_pkg::KHZ_64K)
    else $error("wrong slow CPU clock");
  a_power_control_read_zero: assert property (
    setupPhase && hitPcon |=> prdata[1:0] == 2'h0)
    else $error("stop or idle read back nonzero");
  a_wake_flag_set: assert property (
    wakeHit[3] |=> wakeFlags.rfIrq && wakeFlagPulse.rfIrq)
    else $error("wakeup flag not set");
  a_slow_toggle: assert property ($changed(slowClock) |=> $stable(slowClock) [*8])
    else $error("slow clock toggled too fast");
  a_usb_suspend: assert property (
    wrUsb && pwdata[7:0] == 8'h01 && !wakeSrc.usbResume |=> ##1 !usbActive)
    else $error("USB did not suspend");

endmodule : power_mode_clock_manager

// >>> verif/wake_source_model.sv
/*
  Wake source model: raises the chosen interrupt lines for four cycles.
  Assumes requests from the bench on sys_clk; lines idle low when released.
*/
`timescale 1ns/100ps
module wake_source_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Bench request
  input wire logic fireReq,
  input wire pwr_mgmt_pkg::wake_src_t fireMask,
  // Lines to the manager
  output pwr_mgmt_pkg::wake_src_t wakeSrc
);
  // Cycles left of the current pulse
  logic [2:0] holdLeft;

  // Drive lines just after the edge, drop them when the hold runs out
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      holdLeft <= 3'h0;
      wakeSrc <= '0;
    end
    else if (fireReq)
    begin
      // Radio, timer event, USB interrupt and USB resume levels
      holdLeft <= 3'h4;
      wakeSrc <= fireMask;
    end
    else if (holdLeft != 3'h0)
    begin
      holdLeft <= holdLeft - 3'h1;
      // Last held cycle: release
      if (holdLeft == 3'h1)
        wakeSrc <= '0;
    end
  end
endmodule : wake_source_model

// >>> verif/tb_top.sv
/*
  Self-checking bench for the power mode and clock manager.
  Assumes the design's zero-wait APB slave and the wake source model.
*/
`timescale 1ns/100ps
module tb_top;
  // Stimulus and observed signals
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic programModePin, watchdogResetCause, fireReq;
  pwr_mgmt_pkg::wake_src_t fireMask, wakeSrc, wakeFlagPulse;
  logic cpuClockRun, pllEnable, usbActive, flashProgMode, slowClock;
  logic idleRequest, stopRequest, progMemWrite, baudDouble;
  logic [15:0] cpuClockKhz;
  logic [1:0] radioMode;
  // Bench bookkeeping
  int nFail = 0;
  int checkCount = 0;
  int seed = 32'h53c3;
  int idleCnt = 0, stopCnt = 0, pulseCnt = 0;

  power_mode_clock_manager DUT (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .programModePin(programModePin),
    .watchdogResetCause(watchdogResetCause), .wakeSrc(wakeSrc), .cpuClockRun(cpuClockRun),
    .cpuClockKhz(cpuClockKhz), .pllEnable(pllEnable), .usbActive(usbActive),
    .radioMode(radioMode), .flashProgMode(flashProgMode), .slowClock(slowClock),
    .wakeFlagPulse(wakeFlagPulse), .idleRequest(idleRequest), .stopRequest(stopRequest),
    .progMemWrite(progMemWrite), .baudDouble(baudDouble));

  wake_source_model partner (.sys_clk(sys_clk), .reset_n(reset_n), .fireReq(fireReq),
    .fireMask(fireMask), .wakeSrc(wakeSrc));

  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Count one-cycle pulses from the design
  always @(posedge sys_clk)
  begin
    if (idleRequest === 1'b1) idleCnt++;
    if (stopRequest === 1'b1) stopCnt++;
    if (wakeFlagPulse !== 4'h0) pulseCnt++;
  end

  // Print counts and verdict, end the run
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // Compare and report
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp)
    begin
      nFail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // One APB transfer: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
    output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, idx, d, rd, err);
  endtask : wr

  // Register read with expected value
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 8'h00, rd, err);
    cmp(rd, exp);
  endtask : rdchk

  // Raise wake lines through the partner
  task automatic fire(input logic [3:0] m);
    @(posedge sys_clk);
    fireReq <= 1'b1;
    fireMask <= m;
    @(posedge sys_clk);
    fireReq <= 1'b0;
    repeat (8) @(posedge sys_clk);
  endtask : fire

  // Hold reset for 8 cycles
  task automatic doReset;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : doReset

  // Expected CPU clock in kHz
  function automatic logic [15:0] expKhz(input logic [7:0] c);
    if (c[7])
      case (c[6:4])
        3'h0: return pwr_mgmt_pkg::KHZ_16M;
        3'h1: return pwr_mgmt_pkg::KHZ_12M;
        3'h2: return pwr_mgmt_pkg::KHZ_8M;
        3'h3: return pwr_mgmt_pkg::KHZ_4M;
        default: return pwr_mgmt_pkg::KHZ_1M6;
      endcase
    case (c[1:0])
      2'h0: return pwr_mgmt_pkg::KHZ_4M;
      2'h1: return pwr_mgmt_pkg::KHZ_1M6;
      2'h2: return pwr_mgmt_pkg::KHZ_320K;
      default: return pwr_mgmt_pkg::KHZ_64K;
    endcase
  endfunction : expKhz

  // Enable bit of each wake source, by struct bit
  function automatic int enBit(input int s);
    case (s)
      0: return pwr_mgmt_pkg::IEN_USB_RESUME_EVENT_BIT;
      1: return pwr_mgmt_pkg::IEN_USB_INTERRUPT_BIT;
      2: return pwr_mgmt_pkg::IEN_WU_BIT;
      default: return pwr_mgmt_pkg::IEN_RF_BIT;
    endcase
  endfunction : enBit

  // Watchdog against a hang; the tests need well under 10,000 cycles
  initial
  begin
    #300_000;
    nFail++;
    conclude();
  end

  // Main sequence
  initial
  begin
    logic [7:0] v, cfg, ien;
    logic [31:0] rd;
    logic err, woke;
    int n, expIdle, expStop;
    reset_n = 1'b0;
    {psel, penable, pwrite, fireReq, programModePin, watchdogResetCause} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fireMask = 4'h0;
    expIdle = 0;
    expStop = 0;
    doReset();
    // Reset state
    cmp(32'(cpuClockRun), 32'h1);
    cmp(32'(usbActive), 32'h1);
    cmp(32'(pllEnable), 32'h1);
    cmp(32'(radioMode), 32'h0);
    cmp(32'(cpuClockKhz), 32'(pwr_mgmt_pkg::KHZ_16M));
    rdchk(pwr_mgmt_pkg::IDX_CLOCK_SELECT, 32'h80);
    rdchk(pwr_mgmt_pkg::IDX_POWER_CONTROL, 32'h00);
    rdchk(pwr_mgmt_pkg::IDX_WAKE_CONFIG, 32'h00);
    rdchk(pwr_mgmt_pkg::IDX_RESET_CAUSE, 32'h00);
    // Unmapped address is refused
    apb(1'b0, 8'h10, 8'h00, rd, err);
    cmp(32'(err), 32'h1);
    cmp(rd, 32'h0);
    // Radio moves only by software
    v = 8'($random(seed));
    wr(pwr_mgmt_pkg::IDX_RADIO_CONTROL, v);
    repeat (2) @(posedge sys_clk);
    cmp(32'(radioMode), 32'(v[1:0]));
    // USB suspend, then every clock code with the CPU active
    wr(pwr_mgmt_pkg::IDX_USB_SLEEP, 8'h01);
    repeat (2) @(posedge sys_clk);
    cmp(32'(usbActive), 32'h0);
    for (int i = 0; i < 12; i++)
    begin
      v = 8'($random(seed));
      v[7] = (i < 8);
      if (i < 8) v[6:4] = 3'(i);
      else v[1:0] = 2'(i - 8);
      wr(pwr_mgmt_pkg::IDX_CLOCK_SELECT, v);
      repeat (3) @(posedge sys_clk);
      cmp(32'(pllEnable), 32'(v[7]));
      cmp(32'(cpuClockKhz), 32'(expKhz(v)));
      rdchk(pwr_mgmt_pkg::IDX_CLOCK_SELECT, 32'(v & 8'hf3));
    end
    // Suspended USB with CPU standby turns the PLL off
    wr(pwr_mgmt_pkg::IDX_CLOCK_SELECT, 8'h80);
    wr(pwr_mgmt_pkg::IDX_WAKE_CONFIG, 8'h02);
    wr(pwr_mgmt_pkg::IDX_WAKE_FLAGS, 8'h0f);
    wr(pwr_mgmt_pkg::IDX_CPU_STANDBY, 8'h01);
    repeat (3) @(posedge sys_clk);
    cmp(32'(pllEnable), 32'h0);
    fire(4'h1);
    cmp(32'(usbActive), 32'h1);
    cmp(32'(pllEnable), 32'h1);
    // Writing zero does not stop the CPU
    wr(pwr_mgmt_pkg::IDX_CPU_STANDBY, 8'h00);
    repeat (3) @(posedge sys_clk);
    cmp(32'(cpuClockRun), 32'h1);
    // Every source, code and enable level
    wr(pwr_mgmt_pkg::IDX_USB_SLEEP, 8'h00);
    for (int s = 0; s < 4; s++)
      for (int c = 0; c < 4; c++)
        for (int e = 0; e < 2; e++)
        begin
          cfg = (c == 3) ? 8'hff : 8'($random(seed)); // Corner: every source ignored
          cfg[2 * s +: 2] = 2'(c);
          ien = 8'($random(seed));
          ien[enBit(s)] = 1'(e);
          v = 8'($random(seed));
          wr(pwr_mgmt_pkg::IDX_IRQ_ENABLE, ien);
          wr(pwr_mgmt_pkg::IDX_WAKE_CONFIG, cfg);
          wr(pwr_mgmt_pkg::IDX_CLOCK_SELECT, v);
          wr(pwr_mgmt_pkg::IDX_WAKE_FLAGS, 8'h0f);
          wr(pwr_mgmt_pkg::IDX_CPU_STANDBY, (v[2:0] == 3'h0) ? 8'h04 : {5'h0, v[2:0]});
          repeat (2) @(posedge sys_clk);
          cmp(32'(cpuClockRun), 32'h0);
          fire(4'h1 << s);
          woke = (c == 2) || (c == 0 && e == 1);
          cmp(32'(cpuClockRun), 32'(woke));
          if (!woke)
          begin
            wr(pwr_mgmt_pkg::IDX_WAKE_CONFIG, 8'haa);
            fire(4'h1 << s);
          end
          cmp(32'(cpuClockKhz), 32'(expKhz(v | 8'h80)));
          apb(1'b0, pwr_mgmt_pkg::IDX_WAKE_FLAGS, 8'h00, rd, err);
          cmp(32'(rd[s]), 32'h1);
        end
    cmp(32'(pulseCnt), 32'd33);
    // Power control storage, outputs and pulses
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($random(seed));
      expIdle += v[0];
      expStop += v[1];
      wr(pwr_mgmt_pkg::IDX_POWER_CONTROL, v);
      rdchk(pwr_mgmt_pkg::IDX_POWER_CONTROL, 32'(v & 8'hfc));
      cmp(32'(progMemWrite), 32'(v[4]));
      cmp(32'(baudDouble), 32'(v[7]));
    end
    cmp(32'(idleCnt), 32'(expIdle));
    cmp(32'(stopCnt), 32'(expStop));
    // Slow clock half period and its read-back
    v[0] = slowClock;
    do @(posedge sys_clk); while (slowClock === v[0]);
    v[0] = slowClock;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (slowClock === v[0]);
    cmp(32'(n), 32'(pwr_mgmt_pkg::SLOW_HALF_CYCLES));
    apb(1'b0, pwr_mgmt_pkg::IDX_CPU_STANDBY, 8'h00, rd, err);
    cmp(32'(rd[3]), 32'(slowClock));
    // Program pin overrides power states
    programModePin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cmp(32'(flashProgMode), 32'h1);
    cmp(32'(pllEnable), 32'h0);
    wr(pwr_mgmt_pkg::IDX_CPU_STANDBY, 8'h01);
    repeat (3) @(posedge sys_clk);
    cmp(32'(cpuClockRun), 32'h1);
    programModePin <= 1'b0;
    // Watchdog and other reset causes
    watchdogResetCause <= 1'b1;
    doReset();
    rdchk(pwr_mgmt_pkg::IDX_RESET_CAUSE, 32'h01);
    rdchk(pwr_mgmt_pkg::IDX_POWER_CONTROL, 32'h00);
    watchdogResetCause <= 1'b0;
    doReset();
    rdchk(pwr_mgmt_pkg::IDX_RESET_CAUSE, 32'h00);
    conclude();
  end
endmodule : tb_top
